// File: rpb_host_model.sv
// Host model: legal region layout and the refill or drain range taken on each event
`timescale 1ns/1ps
`default_nettype none
module rpb_host_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic tx_busy,
	input wire logic region_almost_full_event,
	input wire logic region_full_event,
	output logic [7:0] rx_start,
	output logic [7:0] rx_len,
	output logic [7:0] rx_thr,
	output logic [7:0] tx_start,
	output logic [7:0] tx_len,
	output logic [7:0] tx_thr,
	output logic [7:0] fill_lo_r,
	output logic [7:0] fill_hi_r
);
	logic [7:0] base;
	logic [7:0] thr;
	logic [7:0] len;
	assign rx_start = 8'h40;
	assign rx_len = 8'h03;
	assign rx_thr = 8'h01;
	// Two spare bytes plus one keep overflowing check bytes off transmit data
	assign tx_start = rx_start + rx_len + 8'h03;
	assign tx_len = 8'h05;
	assign tx_thr = 8'h02;
	assign base = tx_busy ? tx_start : rx_start;
	assign thr = tx_busy ? tx_thr : rx_thr;
	assign len = tx_busy ? tx_len : rx_len;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fill_lo_r <= 8'h00;
			fill_hi_r <= 8'h00;
		end else if (region_almost_full_event) begin
			fill_lo_r <= base;
			fill_hi_r <= base + thr;
		end else if (region_full_event) begin
			fill_lo_r <= base + thr + 8'h01;
			fill_hi_r <= base + len;
		end
	end
endmodule : rpb_host_model
`default_nettype wire

// File: rpb_pkg.sv
// Package for the rolling packet buffer: register map, limits, states
package rpb_pkg;
	localparam logic [8:0] ADDR_TX_START = 9'h124;
	localparam logic [8:0] ADDR_RX_START = 9'h125;
	localparam logic [8:0] ADDR_RX_THRESH = 9'h134;
	localparam logic [8:0] ADDR_RX_LENGTH = 9'h135;
	localparam logic [8:0] ADDR_TX_THRESH = 9'h136;
	localparam logic [8:0] ADDR_TX_LENGTH = 9'h137;
	localparam logic [8:0] ADDR_EVT_CTRL = 9'h138;
	localparam logic [8:0] ADDR_STATUS = 9'h139;
	localparam logic [7:0] RESET_START = 8'h20;
	localparam logic [7:0] RESET_LENGTH = 8'h00;
	localparam logic [7:0] RESET_THRESH = 8'h00;
	localparam logic [7:0] RESET_EVT_CTRL = 8'h00;
	localparam logic [7:0] RAM_FIRST_DATA = 8'h20;
	localparam int EVT_AF_EN_BIT = 0;
	localparam int EVT_FULL_EN_BIT = 1;
	localparam int PHR_FCS_BIT = 4;
	localparam logic [1:0] FCS16_BYTES = 2'h2;
	typedef enum logic [1:0] {
		RPB_IDLE = 2'b00,
		RPB_TX = 2'b01,
		RPB_RX = 2'b10,
		RPB_RX_FCS = 2'b11
	} rpb_state_type;
endpackage : rpb_pkg

// File: rpb_rolling_buffer.sv
// Rolling packet buffer pointer control for transmit and receive regions
//
// Functional notes
// RQ1 - Packet data only at RAM 0x20..0xFF; lower 32 bytes reserved.
// RQ2 - Transmit fetch starts at tx start address, length bounds the region.
// RQ3 - Software keeps start plus length within 0xFF, or 0xFD with 16-bit check.
// RQ4 - Transmit almost-full event when sent offset reaches the transmit threshold.
// RQ5 - After last transmit byte, fetch pointer wraps to transmit start.
// RQ6 - Transmit full event when last byte of the region is sent, if enabled.
// RQ7 - Host refills lower part on almost-full, upper part on full.
// RQ8 - Transmit loops until end of frame or return-to-phy-on command.
// RQ9 - Receive stores from rx start address, length bounds the region.
// RQ10 - Receive almost-full event when stored offset reaches the receive threshold.
// RQ11 - After last receive location, write pointer wraps to receive start.
// RQ12 - Receive full event when region completely filled, if enabled.
// RQ13 - Host drains lower part on almost-full, upper part on full.
// RQ14 - Receive stops at end of frame, correct check, or phy-on command.
// RQ15 - Two 16-bit check bytes written straight after last payload, no wrap.
// RQ16 - Software leaves two spare bytes after the receive region.
// RQ17 - Transmit start sits three bytes past receive end when adjacent.
// RQ18 - 32-bit check bytes stored as payload under normal wrapping.
// RQ19 - Transmit threshold recommended near half the region.
// RQ20 - Header bit 4 set selects 16-bit check, clear selects 32-bit.
// RQ21 - Pointer returns to start after start plus length; compares use offsets.
// RQ22 - Almost-full and full events reported only when individually enabled.
`timescale 1ns/1ps
`default_nettype none
module rpb_rolling_buffer (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [8:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic tx_start,
	input wire logic tx_byte_done,
	input wire logic tx_eof,
	input wire logic rx_start,
	input wire logic [7:0] rx_phr_low,
	input wire logic rx_byte_valid,
	input wire logic rx_fcs_valid,
	input wire logic rx_eof,
	input wire logic crc_correct,
	input wire logic return_to_phy_on_command,
	output logic [7:0] ram_addr,
	output logic ram_we,
	output logic tx_busy,
	output logic rx_busy,
	output logic region_almost_full_event,
	output logic region_full_event
);
	logic [7:0] tx_region_start_r;
	logic [7:0] rx_region_start_r;
	logic [7:0] tx_almost_full_threshold_r;
	logic [7:0] tx_region_length_r;
	logic [7:0] rx_almost_full_threshold_r;
	logic [7:0] rx_region_length_r;
	logic [7:0] evt_ctrl_r;
	rpb_pkg::rpb_state_type state_r;
	rpb_pkg::rpb_state_type state_nxt;
	logic [7:0] offset_r;
	logic [7:0] offset_nxt;
	logic [7:0] ptr_r;
	logic fcs16_r;
	logic [1:0] fcs_cnt_r;
	logic [7:0] last_addr_r;
	logic step;
	logic stop;
	logic [7:0] cur_start;
	logic [7:0] cur_len;
	logic [7:0] cur_thr;
	logic at_end;
	logic af_hit;
	logic full_hit;

	// Offset wraps to zero after the region's last location
	function automatic logic [7:0] wrap_offset(input logic [7:0] off, input logic [7:0] len);
		wrap_offset = (off >= len) ? 8'h00 : 8'(off + 8'h01);
	endfunction : wrap_offset

	// Packet data must never fall inside the reserved area
	function automatic logic [7:0] clamp_data(input logic [7:0] a);
		clamp_data = (a < rpb_pkg::RAM_FIRST_DATA) ? rpb_pkg::RAM_FIRST_DATA : a; // see RQ1
	endfunction : clamp_data

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_region_start_r <= rpb_pkg::RESET_START;
			rx_region_start_r <= rpb_pkg::RESET_START;
			tx_almost_full_threshold_r <= rpb_pkg::RESET_THRESH;
			tx_region_length_r <= rpb_pkg::RESET_LENGTH;
			rx_almost_full_threshold_r <= rpb_pkg::RESET_THRESH;
			rx_region_length_r <= rpb_pkg::RESET_LENGTH;
			evt_ctrl_r <= rpb_pkg::RESET_EVT_CTRL;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				rpb_pkg::ADDR_TX_START: tx_region_start_r <= clamp_data(reg_wdata);
				rpb_pkg::ADDR_RX_START: rx_region_start_r <= clamp_data(reg_wdata);
				rpb_pkg::ADDR_TX_THRESH: tx_almost_full_threshold_r <= reg_wdata;
				rpb_pkg::ADDR_TX_LENGTH: tx_region_length_r <= reg_wdata;
				rpb_pkg::ADDR_RX_THRESH: rx_almost_full_threshold_r <= reg_wdata;
				rpb_pkg::ADDR_RX_LENGTH: rx_region_length_r <= reg_wdata;
				rpb_pkg::ADDR_EVT_CTRL: evt_ctrl_r <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					rpb_pkg::ADDR_TX_START: reg_rdata <= tx_region_start_r;
					rpb_pkg::ADDR_RX_START: reg_rdata <= rx_region_start_r;
					rpb_pkg::ADDR_TX_THRESH: reg_rdata <= tx_almost_full_threshold_r;
					rpb_pkg::ADDR_TX_LENGTH: reg_rdata <= tx_region_length_r;
					rpb_pkg::ADDR_RX_THRESH: reg_rdata <= rx_almost_full_threshold_r;
					rpb_pkg::ADDR_RX_LENGTH: reg_rdata <= rx_region_length_r;
					rpb_pkg::ADDR_EVT_CTRL: reg_rdata <= evt_ctrl_r;
					rpb_pkg::ADDR_STATUS: reg_rdata <= {5'h00, fcs16_r, state_r};
					default: reg_rdata <= 8'h00;
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	always_comb begin
		cur_start = (state_r == rpb_pkg::RPB_TX) ? tx_region_start_r : rx_region_start_r;
		cur_len = (state_r == rpb_pkg::RPB_TX) ? tx_region_length_r : rx_region_length_r;
		cur_thr = (state_r == rpb_pkg::RPB_TX) ? tx_almost_full_threshold_r : rx_almost_full_threshold_r;
		step = (state_r == rpb_pkg::RPB_TX) ? tx_byte_done : (state_r == rpb_pkg::RPB_RX) && rx_byte_valid;
		at_end = (offset_r == cur_len); // see RQ21
		af_hit = step && (offset_r == cur_thr); // see RQ4, RQ10
		full_hit = step && at_end; // see RQ6, RQ12
		offset_nxt = wrap_offset(offset_r, cur_len); // see RQ5, RQ11
	end

	// Frame ends: transmit on its own end, receive also on correct check
	always_comb begin
		stop = return_to_phy_on_command; // see RQ8, RQ14
		case (state_r)
			rpb_pkg::RPB_TX: stop = stop || tx_eof; // see RQ8
			rpb_pkg::RPB_RX: stop = stop || rx_eof || crc_correct; // see RQ14
			rpb_pkg::RPB_RX_FCS: stop = stop || rx_eof || crc_correct;
			default: stop = stop;
		endcase
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			rpb_pkg::RPB_IDLE: begin
				if (tx_start) begin
					state_nxt = rpb_pkg::RPB_TX;
				end else if (rx_start) begin
					state_nxt = rpb_pkg::RPB_RX;
				end
			end
			rpb_pkg::RPB_TX: if (stop) state_nxt = rpb_pkg::RPB_IDLE;
			rpb_pkg::RPB_RX: begin
				if (stop) begin
					state_nxt = rpb_pkg::RPB_IDLE;
				end else if (rx_fcs_valid && fcs16_r) begin
					state_nxt = rpb_pkg::RPB_RX_FCS; // see RQ15
				end
			end
			rpb_pkg::RPB_RX_FCS: begin
				if (stop || (rx_fcs_valid && fcs_cnt_r == rpb_pkg::FCS16_BYTES - 2'h1)) begin
					state_nxt = rpb_pkg::RPB_IDLE;
				end
			end
			default: state_nxt = rpb_pkg::RPB_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= rpb_pkg::RPB_IDLE;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// Check length is latched from the header when reception begins
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fcs16_r <= 1'b0;
		end else if (clk_en && state_r == rpb_pkg::RPB_IDLE && rx_start && !tx_start) begin
			fcs16_r <= rx_phr_low[rpb_pkg::PHR_FCS_BIT]; // see RQ20
		end
	end

	// Last stored payload address: the 16-bit check bytes follow it even after the region has wrapped
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			last_addr_r <= rpb_pkg::RAM_FIRST_DATA;
		end else if (clk_en) begin
			if (state_r == rpb_pkg::RPB_IDLE) begin
				last_addr_r <= 8'(rx_region_start_r - 8'h01);
			end else if (state_r == rpb_pkg::RPB_RX && step) begin
				last_addr_r <= ptr_r; // see RQ15
			end
		end
	end

	// With the 32-bit check, check bytes arrive as ordinary payload bytes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			offset_r <= 8'h00;
			ptr_r <= rpb_pkg::RAM_FIRST_DATA;
			fcs_cnt_r <= 2'h0;
		end else if (clk_en) begin
			if (state_r == rpb_pkg::RPB_IDLE) begin
				offset_r <= 8'h00;
				fcs_cnt_r <= 2'h0;
				ptr_r <= tx_start ? tx_region_start_r : rx_region_start_r; // see RQ2, RQ9
			end else if (state_r == rpb_pkg::RPB_RX_FCS) begin
				if (rx_fcs_valid) begin
					ptr_r <= 8'(ptr_r + 8'h01); // see RQ15
					fcs_cnt_r <= 2'(fcs_cnt_r + 2'h1);
				end
			end else if (state_r == rpb_pkg::RPB_RX && rx_fcs_valid && fcs16_r) begin
				ptr_r <= 8'(last_addr_r + 8'h01); // see RQ15
			end else if (step) begin
				offset_r <= offset_nxt; // see RQ18, RQ21
				ptr_r <= 8'(cur_start + offset_nxt);
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			region_almost_full_event <= 1'b0;
			region_full_event <= 1'b0;
		end else if (clk_en) begin
			region_almost_full_event <= af_hit && evt_ctrl_r[rpb_pkg::EVT_AF_EN_BIT]; // see RQ22
			region_full_event <= full_hit && evt_ctrl_r[rpb_pkg::EVT_FULL_EN_BIT]; // see RQ22
		end
	end

	always_comb begin
		ram_addr = ptr_r;
		ram_we = (state_r == rpb_pkg::RPB_RX && rx_byte_valid) || (state_r == rpb_pkg::RPB_RX_FCS && rx_fcs_valid);
		tx_busy = (state_r == rpb_pkg::RPB_TX);
		rx_busy = (state_r == rpb_pkg::RPB_RX) || (state_r == rpb_pkg::RPB_RX_FCS);
	end

	a_tx_wrap_start: assert property (@(posedge clock) disable iff (rst) // see RQ5
		clk_en && state_r == rpb_pkg::RPB_TX && tx_byte_done && at_end && !stop |=> ptr_r == tx_region_start_r)
		else $error("transmit pointer did not wrap to start");

	a_rx_wrap_start: assert property (@(posedge clock) disable iff (rst) // see RQ11
		clk_en && state_r == rpb_pkg::RPB_RX && rx_byte_valid && at_end && !stop && !rx_fcs_valid
		|=> ptr_r == rx_region_start_r)
		else $error("receive pointer did not wrap to start");

	a_tx_ptr_step: assert property (@(posedge clock) disable iff (rst) // see RQ2
		clk_en && state_r == rpb_pkg::RPB_TX && tx_byte_done && !at_end && !stop
		|=> ram_addr == 8'($past(ram_addr) + 8'h01))
		else $error("transmit fetch did not advance by one");

	a_rx_ptr_step: assert property (@(posedge clock) disable iff (rst) // see RQ9
		clk_en && state_r == rpb_pkg::RPB_RX && rx_byte_valid && !rx_fcs_valid && !at_end && !stop
		|=> ram_addr == 8'($past(ram_addr) + 8'h01))
		else $error("receive store did not advance by one");

	a_af_event_when: assert property (@(posedge clock) disable iff (rst) // see RQ4, RQ10
		clk_en && af_hit && evt_ctrl_r[rpb_pkg::EVT_AF_EN_BIT] |=> region_almost_full_event)
		else $error("almost-full event missing at threshold");

	a_full_event_when: assert property (@(posedge clock) disable iff (rst) // see RQ6, RQ12
		clk_en && full_hit && evt_ctrl_r[rpb_pkg::EVT_FULL_EN_BIT] |=> region_full_event)
		else $error("full event missing at region end");

	a_events_masked: assert property (@(posedge clock) disable iff (rst) // see RQ22
		clk_en && !evt_ctrl_r[rpb_pkg::EVT_FULL_EN_BIT] && !evt_ctrl_r[rpb_pkg::EVT_AF_EN_BIT]
		|=> !region_full_event && !region_almost_full_event)
		else $error("event reported while disabled");

	a_af_masked: assert property (@(posedge clock) disable iff (rst) // see RQ22
		clk_en && !evt_ctrl_r[rpb_pkg::EVT_AF_EN_BIT] |=> !region_almost_full_event)
		else $error("almost-full event reported while disabled");

	a_full_masked: assert property (@(posedge clock) disable iff (rst) // see RQ22
		clk_en && !evt_ctrl_r[rpb_pkg::EVT_FULL_EN_BIT] |=> !region_full_event)
		else $error("full event reported while disabled");

	a_tx_first_fetch: assert property (@(posedge clock) disable iff (rst) // see RQ2
		clk_en && state_r == rpb_pkg::RPB_IDLE && tx_start |=> tx_busy && ptr_r == $past(tx_region_start_r))
		else $error("transmit did not begin at start address");

	a_rx_first_store: assert property (@(posedge clock) disable iff (rst) // see RQ9
		clk_en && state_r == rpb_pkg::RPB_IDLE && rx_start && !tx_start
		|=> rx_busy && ptr_r == $past(rx_region_start_r))
		else $error("receive did not begin at start address");

	a_fcs16_latch: assert property (@(posedge clock) disable iff (rst) // see RQ20
		clk_en && state_r == rpb_pkg::RPB_IDLE && rx_start && !tx_start
		|=> fcs16_r == $past(rx_phr_low[rpb_pkg::PHR_FCS_BIT]))
		else $error("check length not taken from header");

	a_tx_stop_idle: assert property (@(posedge clock) disable iff (rst) // see RQ8
		clk_en && state_r == rpb_pkg::RPB_TX && (tx_eof || return_to_phy_on_command) |=> !tx_busy)
		else $error("transmit did not stop");

	a_rx_stop_idle: assert property (@(posedge clock) disable iff (rst) // see RQ14
		clk_en && state_r == rpb_pkg::RPB_RX && (rx_eof || crc_correct || return_to_phy_on_command) |=> !rx_busy)
		else $error("receive did not stop");

	a_rx_fcs_stop: assert property (@(posedge clock) disable iff (rst) // see RQ14
		clk_en && state_r == rpb_pkg::RPB_RX_FCS && (rx_eof || crc_correct || return_to_phy_on_command)
		|=> !rx_busy)
		else $error("receive did not stop during check bytes");

	sequence s_fcs_enter;
		clk_en && state_r == rpb_pkg::RPB_RX && rx_fcs_valid && fcs16_r && !stop;
	endsequence

	a_fcs_follow_payload: assert property (@(posedge clock) disable iff (rst) // see RQ15
		s_fcs_enter |=> ram_addr == 8'($past(last_addr_r) + 8'h01) && state_r == rpb_pkg::RPB_RX_FCS)
		else $error("check bytes do not follow last payload byte");

	sequence s_fcs_byte;
		clk_en && state_r == rpb_pkg::RPB_RX_FCS && rx_fcs_valid && !stop;
	endsequence

	a_fcs_no_wrap: assert property (@(posedge clock) disable iff (rst) // see RQ15
		s_fcs_byte |=> ptr_r == 8'($past(ptr_r) + 8'h01))
		else $error("check byte pointer wrapped");

	a_rdata_idle: assert property (@(posedge clock) disable iff (rst)
		clk_en && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not cleared after read cycle");

	a_ram_data_area: assert property (@(posedge clock) disable iff (rst) // see RQ1
		ram_we |-> ram_addr >= rpb_pkg::RAM_FIRST_DATA)
		else $error("packet store inside reserved area");

	a_data_area: assert property (@(posedge clock) disable iff (rst) // see RQ1
		tx_region_start_r >= rpb_pkg::RAM_FIRST_DATA && rx_region_start_r >= rpb_pkg::RAM_FIRST_DATA)
		else $error("region start inside reserved area");
endmodule : rpb_rolling_buffer
`default_nettype wire

// File: test_rpb_rolling_buffer.sv
// Testbench for the rolling packet buffer pointer control
`timescale 1ns/1ps
`default_nettype none
module test_rpb_rolling_buffer;
	logic clock, rst, ce, reg_wr, reg_rd, ram_we, tx_busy, rx_busy, af, fe, we_seen;
	logic [8:0] strb, reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rx_phr_low, ram_addr, a_seen, rs, rl, rt, ts, tl, tt, flo, fhi;
	logic [8:0] ra[8];
	logic [7:0] rv[6];
	int miscompares, total_checks;
	rpb_rolling_buffer dut_u (.clock(clock), .rst(rst), .clk_en(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tx_start(strb[0]), .tx_byte_done(strb[1]), .tx_eof(strb[2]), .rx_start(strb[3]),
		.rx_phr_low(rx_phr_low), .rx_byte_valid(strb[4]), .rx_fcs_valid(strb[5]), .rx_eof(strb[6]),
		.crc_correct(strb[7]), .return_to_phy_on_command(strb[8]), .ram_addr(ram_addr), .ram_we(ram_we),
		.tx_busy(tx_busy), .rx_busy(rx_busy), .region_almost_full_event(af), .region_full_event(fe));
	rpb_host_model host_u (.clock(clock), .rst(rst), .tx_busy(tx_busy), .region_almost_full_event(af),
		.region_full_event(fe), .rx_start(rs), .rx_len(rl), .rx_thr(rt), .tx_start(ts), .tx_len(tl),
		.tx_thr(tt), .fill_lo_r(flo), .fill_hi_r(fhi));
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [8:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk("reg", reg_rdata, exp);
	endtask : rdchk
	// Strobes one cycle; write strobe and address are caught before the taking edge
	task automatic hit(input int k);
		@(posedge clock);
		strb <= 9'h001 << k;
		#1;
		we_seen = ram_we;
		a_seen = ram_addr;
		@(posedge clock);
		strb <= 9'h000;
		#1;
	endtask : hit
	task automatic lap(input int k, input int n, input logic [7:0] st, ln, th, input logic we, ev);
		int off;
		for (int i = 0; i < n; i++) begin
			off = i % (int'(ln) + 1);
			hit(k);
			chk("we", 8'(we_seen), 8'(we));
			chk("addr", a_seen, 8'(int'(st) + off));
			chk("ptr", ram_addr, off == int'(ln) ? st : 8'(int'(st) + off + 1));
			chk("almost_full", 8'(af), 8'(ev && off == int'(th)));
			chk("full", 8'(fe), 8'(ev && off == int'(ln)));
			if (ev && (off == int'(th) || off == int'(ln))) begin
				@(posedge clock);
				#1;
				chk("fill_lo", flo, off == int'(th) ? st : 8'(int'(st) + int'(th) + 1));
				chk("fill_hi", fhi, off == int'(th) ? 8'(int'(st) + int'(th)) : 8'(int'(st) + int'(ln)));
			end
		end
	endtask : lap
	task automatic final_report;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	initial begin
		ra = '{rpb_pkg::ADDR_TX_START, rpb_pkg::ADDR_RX_START, rpb_pkg::ADDR_RX_THRESH, rpb_pkg::ADDR_RX_LENGTH,
			rpb_pkg::ADDR_TX_THRESH, rpb_pkg::ADDR_TX_LENGTH, rpb_pkg::ADDR_EVT_CTRL, rpb_pkg::ADDR_STATUS};
		rst = 1'b1;
		ce = 1'b1;
		strb = 9'h000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 9'h000;
		reg_wdata = 8'h00;
		rx_phr_low = 8'h00;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rdchk(ra[i], i < 2 ? rpb_pkg::RESET_START : 8'h00);
		rdchk(9'h100, 8'h00);
		wr(rpb_pkg::ADDR_TX_START, 8'h10);
		rdchk(rpb_pkg::ADDR_TX_START, rpb_pkg::RAM_FIRST_DATA);
		rv = '{ts, rs, rt, rl, tt, tl};
		for (int i = 0; i < 6; i++) wr(ra[i], rv[i]);
		wr(rpb_pkg::ADDR_EVT_CTRL, 8'h03);
		for (int i = 0; i < 7; i++) rdchk(ra[i], i < 6 ? rv[i] : 8'h03);
		hit(0);
		chk("tx_ptr", ram_addr, ts);
		chk("tx_busy", 8'(tx_busy), 8'h01);
		@(posedge clock);
		ce <= 1'b0;
		hit(1);
		chk("freeze_ptr", ram_addr, ts);
		@(posedge clock);
		ce <= 1'b1;
		lap(1, 8, ts, tl, tt, 1'b0, 1'b1);
		hit(2);
		chk("tx_busy", 8'(tx_busy), 8'h00);
		@(posedge clock);
		rx_phr_low <= 8'h10;
		hit(3);
		chk("rx_ptr", ram_addr, rs);
		rdchk(rpb_pkg::ADDR_STATUS, 8'h06);
		lap(4, 4, rs, rl, rt, 1'b1, 1'b1);
		hit(5);
		chk("fcs_we", 8'(we_seen), 8'h00);
		for (int j = 0; j < 2; j++) begin
			hit(5);
			chk("fcs_we", 8'(we_seen), 8'h01);
			chk("fcs_addr", a_seen, rs + rl + 8'h01 + 8'(j));
		end
		chk("fcs_done", 8'(rx_busy), 8'h00);
		hit(3);
		hit(7);
		chk("rx_busy", 8'(rx_busy), 8'h00);
		wr(rpb_pkg::ADDR_EVT_CTRL, 8'h00);
		rx_phr_low <= 8'h00;
		hit(3);
		rdchk(rpb_pkg::ADDR_STATUS, 8'h02);
		lap(4, 6, rs, rl, rt, 1'b1, 1'b0);
		hit(6);
		chk("rx_busy", 8'(rx_busy), 8'h00);
		hit(0);
		hit(8);
		chk("tx_busy", 8'(tx_busy), 8'h00);
		hit(3);
		hit(8);
		chk("rx_busy", 8'(rx_busy), 8'h00);
		final_report();
	end
endmodule : test_rpb_rolling_buffer
`default_nettype wire
